// >>> verilog/cac_ctrl.sv
// Control and status registers of the crypto accelerator, on the peripheral bus.
// Assumes engines report completion as one-cycle pulses synchronous to mclk.
module cac_ctrl
    import cac_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cac_event_type evt,
    input wire logic in_valid,
    input wire logic in_full,
    input wire logic [31:0] in_data,
    input wire logic out_valid,
    input wire logic out_full,
    input wire logic [31:0] out_data,
    output logic in_q_valid,
    output logic [31:0] in_q_data,
    output logic out_q_valid,
    output logic [31:0] out_q_data,
    output cac_steer_type steer,
    output logic engine_reset,
    output logic init_start,
    output logic irq
);
    // ==========================================================
    // Helper functions.
    // Reverses the four bytes of a word.
    function automatic logic [31:0] swap32(input logic [31:0] w);
        swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    // Next value of a unit flag; a set event always beats a software clear.
    function automatic logic flag_next(input logic f, input logic e, input logic wr,
        input logic w1c, input logic w);
        if (e) begin
            flag_next = 1'b1;
        end else if (wr) begin
            flag_next = w1c ? (f & ~w) : w;
        end else begin
            flag_next = f;
        end
    endfunction

    // ==========================================================
    // Register state.
    logic done, rdy, err, maa_done, cph_done, hsh_done, gls_done, dma_done;
    logic dmsk, fmode, bsi, bso, hsrc, int_en, rst_bit;
    logic [1:0] rdsrc, wrsrc, ksrc;
    logic [2:0] cmode, calg, halg;
    logic key_ld, dec, last, hxor, init_rdy, stc_prev;
    logic acc, wr_glob, wr_ciph, wr_dig, mapped, maa_fin, dma_set, any_evt;
    logic [31:0] glob_word, ciph_word, dig_word;

    // ==========================================================
    // Bus decode. Writes take effect in the access phase; no wait states.
    assign acc = psel & penable & clk_en;
    assign wr_glob = acc & pwrite & (paddr == CAC_OFS_GLOBAL);
    assign wr_ciph = acc & pwrite & (paddr == CAC_OFS_CIPHER);
    assign wr_dig = acc & pwrite & (paddr == CAC_OFS_DIGEST);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_comb begin
        if (paddr == CAC_OFS_GLOBAL) begin
            mapped = 1'b1;
        end else if (paddr == CAC_OFS_CIPHER) begin
            mapped = 1'b1;
        end else if (paddr == CAC_OFS_DIGEST) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Completion events feeding the sticky aggregate bit.
    assign maa_fin = stc_prev & ~evt.maa_start;
    assign dma_set = evt.dma_done | evt.key_load_done;
    assign any_evt = maa_fin | evt.cipher_done | evt.hash_done | evt.galois_done
        | (dma_set & dmsk);

    // ==========================================================
    // Aggregate done bit: a global write loads it from its own bit, whatever the flag mode, unless a completion event sets it in the same cycle.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            done <= CAC_FLAG_RST;
        end else if (clk_en) begin
            if (any_evt) begin
                done <= 1'b1;
            end else if (wr_glob) begin
                done <= pwdata[CAC_DONE];
            end
        end
    end

    // Unit completion flags under the selected clearing policy.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cph_done <= CAC_FLAG_RST;
            hsh_done <= CAC_FLAG_RST;
            gls_done <= CAC_FLAG_RST;
            dma_done <= CAC_FLAG_RST;
        end else if (clk_en) begin
            cph_done <= flag_next(cph_done, evt.cipher_done, wr_glob, fmode,
                pwdata[CAC_CPH]);
            hsh_done <= flag_next(hsh_done, evt.hash_done, wr_glob, fmode,
                pwdata[CAC_HSH]);
            gls_done <= flag_next(gls_done, evt.galois_done, wr_glob, fmode,
                pwdata[CAC_GLS]);
            dma_done <= flag_next(dma_done, dma_set, wr_glob, fmode,
                pwdata[CAC_DMA]);
        end
    end

    // Arithmetic done follows the start level; software may only write it when idle.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            maa_done <= CAC_FLAG_RST;
            stc_prev <= 1'b0;
        end else if (clk_en) begin
            stc_prev <= evt.maa_start;
            if (evt.maa_start) begin
                maa_done <= 1'b0;
            end else if (maa_fin) begin
                maa_done <= 1'b1;
            end else if (wr_glob) begin
                maa_done <= pwdata[CAC_MAA];
            end
        end
    end

    // ==========================================================
    // Engine reset request, ready handshake and bus error.
    // A new request in the same cycle as a completion keeps ready low.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rst_bit <= 1'b0;
            rdy <= CAC_RDY_RST;
        end else if (clk_en) begin
            rst_bit <= wr_glob & pwdata[CAC_RST];
            if (wr_glob & pwdata[CAC_RST]) begin
                rdy <= 1'b0;
            end else if (evt.engine_reset_done) begin
                rdy <= 1'b1;
            end
        end
    end

    // Software cannot clear the error; a block reset request does.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            err <= CAC_FLAG_RST;
        end else if (clk_en) begin
            if (evt.bus_error) begin
                err <= 1'b1;
            end else if (wr_glob & pwdata[CAC_RST]) begin
                err <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Global control fields, kept across an engine reset.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dmsk <= 1'b0;
            fmode <= 1'b0;
            rdsrc <= 2'h0;
            wrsrc <= 2'h0;
            bsi <= 1'b0;
            bso <= 1'b0;
            hsrc <= 1'b0;
            int_en <= 1'b0;
        end else if (clk_en && wr_glob) begin
            dmsk <= pwdata[CAC_DMSK];
            fmode <= pwdata[CAC_FMODE];
            rdsrc <= pwdata[CAC_RDSRC +: 2];
            wrsrc <= pwdata[CAC_WRSRC +: 2];
            bsi <= pwdata[CAC_BSI];
            bso <= pwdata[CAC_BSO];
            hsrc <= pwdata[CAC_HSRC];
            int_en <= pwdata[CAC_INTEN];
        end
    end

    // Cipher control word; the key load bit drops when the key has arrived.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmode <= 3'h0;
            calg <= 3'h0;
            ksrc <= 2'h0;
            key_ld <= 1'b0;
            dec <= 1'b0;
        end else if (clk_en) begin
            if (wr_ciph) begin
                cmode <= pwdata[CAC_CMODE +: 3];
                calg <= pwdata[CAC_CALG +: 3];
                ksrc <= pwdata[CAC_KSRC +: 2];
                key_ld <= pwdata[CAC_KEY];
                dec <= pwdata[CAC_DEC];
            end else if (evt.key_load_done) begin
                key_ld <= 1'b0;
            end
        end
    end

    // Digest control word with its self-clearing bits.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            halg <= 3'h0;
            last <= 1'b0;
            hxor <= 1'b0;
        end else if (clk_en) begin
            if (wr_dig) begin
                halg <= pwdata[CAC_HALG +: 3];
                last <= pwdata[CAC_LAST];
                hxor <= pwdata[CAC_XOR];
            end else begin
                if (evt.hash_done) begin
                    last <= 1'b0;
                end
                if (evt.key_load_done) begin
                    hxor <= 1'b0;
                end
            end
        end
    end

    // Init bit reads low from the request until the constants are in.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            init_rdy <= 1'b0;
            init_start <= 1'b0;
        end else if (clk_en) begin
            init_start <= wr_dig & pwdata[CAC_INIT];
            if (wr_dig & pwdata[CAC_INIT]) begin
                init_rdy <= 1'b0;
            end else if (evt.init_loaded) begin
                init_rdy <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read words; reserved bits read as zero.
    always_comb begin
        glob_word = CAC_WORD_RST;
        glob_word[CAC_DONE] = done;
        glob_word[CAC_RDY] = rdy;
        glob_word[CAC_ERR] = err;
        glob_word[CAC_MAA] = maa_done;
        glob_word[CAC_CPH] = cph_done;
        glob_word[CAC_HSH] = hsh_done;
        glob_word[CAC_GLS] = gls_done;
        glob_word[CAC_DMA] = dma_done;
        glob_word[CAC_DMSK] = dmsk;
        glob_word[CAC_FMODE] = fmode;
        glob_word[CAC_RDSRC +: 2] = rdsrc;
        glob_word[CAC_WRSRC +: 2] = wrsrc;
        glob_word[CAC_BSI] = bsi;
        glob_word[CAC_BSO] = bso;
        glob_word[CAC_HSRC] = hsrc;
        glob_word[CAC_INTEN] = int_en;
        glob_word[CAC_RST] = rst_bit;
        ciph_word = CAC_WORD_RST;
        ciph_word[CAC_CMODE +: 3] = cmode;
        ciph_word[CAC_CALG +: 3] = calg;
        ciph_word[CAC_KSRC +: 2] = ksrc;
        ciph_word[CAC_KEY] = key_ld;
        ciph_word[CAC_DEC] = dec;
        dig_word = CAC_WORD_RST;
        dig_word[CAC_LAST] = last;
        dig_word[CAC_HALG +: 3] = halg;
        dig_word[CAC_XOR] = hxor;
        dig_word[CAC_INIT] = init_rdy;
    end

    // Read data is captured in the setup phase so it comes from a flip-flop.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= CAC_WORD_RST;
        end else if (clk_en && psel && !penable) begin
            if (paddr == CAC_OFS_GLOBAL) begin
                prdata <= glob_word;
            end else if (paddr == CAC_OFS_CIPHER) begin
                prdata <= ciph_word;
            end else if (paddr == CAC_OFS_DIGEST) begin
                prdata <= dig_word;
            end else begin
                prdata <= CAC_WORD_RST;
            end
        end
    end

    // ==========================================================
    // Steering decode; reserved codes switch the engine off rather than guess.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            steer <= '0;
        end else if (clk_en) begin
            steer.rd_from_dma <= (rdsrc == CAC_RD_DMA);
            steer.rd_from_rng <= (rdsrc == CAC_RD_RNG);
            steer.wr_from_cipher <= (wrsrc == CAC_WR_CIPH);
            steer.wr_from_rdfifo <= (wrsrc == CAC_WR_RDF);
            steer.hash_from_out <= hsrc;
            steer.key_from_sw <= ~ksrc[1];
            steer.key_region_hi <= ksrc[1] & ksrc[0];
            steer.key_from_dma <= key_ld;
            steer.cipher_on <= (calg != CAC_C_OFF) && (calg <= CAC_TDEA)
                && (cmode <= CAC_CTR);
            steer.decrypt <= dec;
            steer.cipher_mode <= cmode;
            steer.cipher_alg <= calg;
            steer.hash_on <= (halg != CAC_H_OFF) && (halg <= CAC_SHA512);
            steer.hash_alg <= halg;
            steer.hash_last <= last;
            steer.hmac_xor <= hxor;
        end
    end

    // ==========================================================
    // Byte swap stage; a partial word passes unswapped.
    always_ff @(posedge mclk) begin
        if (sys_rst || rst_bit) begin
            in_q_valid <= 1'b0;
            in_q_data <= CAC_WORD_RST;
            out_q_valid <= 1'b0;
            out_q_data <= CAC_WORD_RST;
        end else if (clk_en) begin
            in_q_valid <= in_valid;
            out_q_valid <= out_valid;
            if (in_valid) begin
                in_q_data <= (bsi && in_full) ? swap32(in_data) : in_data;
            end
            if (out_valid) begin
                out_q_data <= (bso && out_full) ? swap32(out_data) : out_data;
            end
        end
    end

    assign engine_reset = rst_bit;
    // Level request; stays up until the cause is cleared or masked.
    assign irq = int_en & (done | err);

    // ==========================================================
    // Checks.
    done_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && any_evt |=> done)
        else $error("done not set by unit completion");
    dma_mask_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && evt.dma_done && !dmsk && !done && !maa_fin && !evt.cipher_done
        && !evt.hash_done && !evt.galois_done && !wr_glob |=> !done && dma_done)
        else $error("masked dma completion touched done");
    ready_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && wr_glob && pwdata[CAC_RST] |=> !rdy && engine_reset ##1 !engine_reset)
        else $error("ready or reset pulse wrong");
    err_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        err && !(wr_glob && pwdata[CAC_RST]) |=> err)
        else $error("bus error cleared without block reset");
    maa_mirror_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && evt.maa_start |=> !maa_done)
        else $error("arithmetic done high while running");
    flag_w1c_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_glob && fmode && !pwdata[CAC_HSH] && hsh_done |=> hsh_done)
        else $error("write zero cleared flag in clear mode");
    cipher_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && evt.cipher_done |=> cph_done && done)
        else $error("cipher completion lost");
    swap_in_a: assert property (@(posedge mclk) disable iff (sys_rst || rst_bit)
        clk_en && in_valid && in_full && bsi |=> in_q_data == swap32($past(in_data)))
        else $error("input word not swapped");
    key_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && evt.key_load_done && !wr_ciph |=> !key_ld && dma_done)
        else $error("key load bit not cleared");
    last_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && evt.hash_done && !wr_dig |=> !last && hsh_done)
        else $error("last block bit not cleared");
    init_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && wr_dig && pwdata[CAC_INIT] |=> !init_rdy && init_start)
        else $error("init bit not low during load");
    irq_level_a: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && int_en && any_evt && !wr_glob |=> irq)
        else $error("interrupt not raised by completion");
endmodule

// >>> verilog/cac_pkg.sv
// Constants, field layout and carrier types for the accelerator control registers.
// Assumes a single 250 MHz clock and word-aligned peripheral bus accesses.
package cac_pkg;
    // ==========================================================
    // Register offsets.
    localparam logic [7:0] CAC_OFS_GLOBAL = 8'h00;
    localparam logic [7:0] CAC_OFS_CIPHER = 8'h04;
    localparam logic [7:0] CAC_OFS_DIGEST = 8'h08;
    // ==========================================================
    // Global control word fields.
    localparam int CAC_DONE = 31;
    localparam int CAC_RDY = 30;
    localparam int CAC_ERR = 29;
    localparam int CAC_MAA = 28;
    localparam int CAC_CPH = 27;
    localparam int CAC_HSH = 26;
    localparam int CAC_GLS = 25;
    localparam int CAC_DMA = 24;
    localparam int CAC_DMSK = 15;
    localparam int CAC_FMODE = 14;
    localparam int CAC_RDSRC = 10;
    localparam int CAC_WRSRC = 8;
    localparam int CAC_BSI = 5;
    localparam int CAC_BSO = 4;
    localparam int CAC_HSRC = 2;
    localparam int CAC_INTEN = 1;
    localparam int CAC_RST = 0;
    // ==========================================================
    // Cipher and digest control fields.
    localparam int CAC_CMODE = 8;
    localparam int CAC_CALG = 4;
    localparam int CAC_KSRC = 2;
    localparam int CAC_KEY = 1;
    localparam int CAC_DEC = 0;
    localparam int CAC_LAST = 5;
    localparam int CAC_HALG = 2;
    localparam int CAC_XOR = 1;
    localparam int CAC_INIT = 0;
    // ==========================================================
    // Reset values.
    localparam logic CAC_RDY_RST = 1'b1;
    localparam logic CAC_FLAG_RST = 1'b0;
    localparam logic [31:0] CAC_WORD_RST = 32'h0000_0000;
    // ==========================================================
    // Field encodings.
    typedef enum logic [1:0] {CAC_RD_OFF = 2'h0, CAC_RD_DMA = 2'h1, CAC_RD_RNG = 2'h2,
        CAC_RD_RSV = 2'h3} cac_rdsrc_type;
    typedef enum logic [1:0] {CAC_WR_NONE = 2'h0, CAC_WR_CIPH = 2'h1, CAC_WR_RDF = 2'h2,
        CAC_WR_RSV = 2'h3} cac_wrsrc_type;
    typedef enum logic [2:0] {CAC_ECB = 3'h0, CAC_CBC = 3'h1, CAC_CFB = 3'h2,
        CAC_OFB = 3'h3, CAC_CTR = 3'h4} cac_cmode_type;
    typedef enum logic [2:0] {CAC_C_OFF = 3'h0, CAC_AES128 = 3'h1, CAC_AES192 = 3'h2,
        CAC_AES256 = 3'h3, CAC_DES = 3'h4, CAC_TDEA = 3'h5} cac_calg_type;
    typedef enum logic [2:0] {CAC_H_OFF = 3'h0, CAC_SHA1 = 3'h1, CAC_SHA224 = 3'h2,
        CAC_SHA256 = 3'h3, CAC_SHA384 = 3'h4, CAC_SHA512 = 3'h5} cac_halg_type;
    // ==========================================================
    // Decoded steering handed to the datapaths.
    typedef struct packed {
        logic rd_from_dma;
        logic rd_from_rng;
        logic wr_from_cipher;
        logic wr_from_rdfifo;
        logic hash_from_out;
        logic key_from_sw;
        logic key_region_hi;
        logic key_from_dma;
        logic cipher_on;
        logic decrypt;
        logic [2:0] cipher_mode;
        logic [2:0] cipher_alg;
        logic hash_on;
        logic [2:0] hash_alg;
        logic hash_last;
        logic hmac_xor;
    } cac_steer_type;
    // Completion events from the engines, one-cycle pulses except the start level.
    typedef struct packed {
        logic maa_start;
        logic cipher_done;
        logic hash_done;
        logic galois_done;
        logic dma_done;
        logic key_load_done;
        logic bus_error;
        logic engine_reset_done;
        logic init_loaded;
    } cac_event_type;
endpackage

// >>> tb/tb_top.sv
// Self-checking bench for the accelerator control and status registers.
// Assumes the bench alone drives every input of cac_ctrl, bus strobes included.
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Stimulus, observed outputs and the device.
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clk_en = 1'b1;
    logic in_valid = 1'b0, in_full = 1'b0, out_valid = 1'b0, out_full = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, in_data = 32'h1122_3344, out_data = 32'h5566_7788;
    logic [31:0] prdata, in_q_data, out_q_data;
    logic pready, pslverr, in_q_valid, out_q_valid, engine_reset, init_start, irq;
    cac_pkg::cac_event_type evt = '0;
    cac_pkg::cac_steer_type steer;
    int fail_count = 0, total_checks = 0;
    int k;
    cac_ctrl dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .in_valid(in_valid), .in_full(in_full), .in_data(in_data),
        .out_valid(out_valid), .out_full(out_full), .out_data(out_data),
        .in_q_valid(in_q_valid), .in_q_data(in_q_data), .out_q_valid(out_q_valid),
        .out_q_data(out_q_data), .steer(steer), .engine_reset(engine_reset),
        .init_start(init_start), .irq(irq));
    // The clock toggles every 2 ns, a period of 4 ns.
    initial begin
        forever #2 mclk = ~mclk;
    end
    // ==========================================================
    // Bus cycles: setup, then access; data is taken at the closing edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic er);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= a;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        `CHK("prdata", e, prdata)
        `CHK("pslverr", er, pslverr)
        `CHK("pready", 1'b1, pready)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Engine events are one-cycle pulses.
    task automatic pulse(input logic [8:0] e);
        @(posedge mclk);
        evt <= e;
        @(posedge mclk);
        evt <= '0;
    endtask
    task automatic settle;
        repeat (2) @(negedge mclk);
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_reset;
        rc(8'h00, 32'h4000_0000, 1'b0);
        rc(8'h04, 32'h0, 1'b0);
        wr(8'h0C, 32'hFFFF_FFFF);
        rc(8'h0C, 32'h0, 1'b1);
        rc(8'h00, 32'h4000_0000, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_flags;
        wr(8'h00, 32'h0000_0002);
        pulse(9'h080);
        rc(8'h00, 32'hC800_0002, 1'b0);
        @(negedge mclk) `CHK("irq", 1'b1, irq)
        wr(8'h00, 32'h0000_0002);
        @(negedge mclk) `CHK("irq", 1'b0, irq)
        pulse(9'h060);
        rc(8'h00, 32'hC600_0002, 1'b0);
        wr(8'h00, 32'h0400_4002);
        rc(8'h00, 32'h4400_4002, 1'b0);
        wr(8'h00, 32'h0000_4002);
        rc(8'h00, 32'h4400_4002, 1'b0);
        wr(8'h00, 32'h0400_4002);
        rc(8'h00, 32'h4000_4002, 1'b0);
        wr(8'h00, 32'h0000_0002);
        pulse(9'h010);
        rc(8'h00, 32'h4100_0002, 1'b0);
        wr(8'h00, 32'h0000_8002);
        pulse(9'h010);
        rc(8'h00, 32'hC100_8002, 1'b0);
        $display("test flags done");
    endtask
    task automatic t_maa;
        wr(8'h00, 32'h1000_0000);
        rc(8'h00, 32'h5000_0000, 1'b0);
        @(posedge mclk) evt <= 9'h100;
        rc(8'h00, 32'h4000_0000, 1'b0);
        wr(8'h00, 32'h1000_0000);
        rc(8'h00, 32'h4000_0000, 1'b0);
        @(posedge mclk) evt <= 9'h000;
        rc(8'h00, 32'hD000_0000, 1'b0);
        $display("test maa done");
    endtask
    task automatic t_err_rst;
        wr(8'h00, 32'h0000_0002);
        wr(8'h04, 32'h0000_0115);
        pulse(9'h004);
        rc(8'h00, 32'h6000_0002, 1'b0);
        @(negedge mclk) `CHK("irq", 1'b1, irq)
        wr(8'h00, 32'h0000_0002);
        rc(8'h00, 32'h6000_0002, 1'b0);
        wr(8'h00, 32'h0000_0003);
        k = 0;
        repeat (4) begin
            @(negedge mclk) k += engine_reset;
        end
        `CHK("engine_reset", 1, k)
        rc(8'h00, 32'h0000_0002, 1'b0);
        pulse(9'h002);
        rc(8'h00, 32'h4000_0002, 1'b0);
        rc(8'h04, 32'h0000_0115, 1'b0);
        // A write while the clock enable is low must be ignored.
        @(posedge mclk) clk_en <= 1'b0;
        wr(8'h04, 32'h0000_0000);
        @(posedge mclk) clk_en <= 1'b1;
        rc(8'h04, 32'h0000_0115, 1'b0);
        $display("test error and reset done");
    endtask
    task automatic t_cipher;
        logic [31:0] d;
        for (int i = 0; i < 7; i++) begin
            d = (32'(i % 5) << 8) | (32'(i) << 4) | (32'(i % 4) << 2) | 32'(i % 2);
            wr(8'h04, d);
            settle();
            `CHK("mode", 3'(i % 5), steer.cipher_mode)
            `CHK("alg", 3'(i), steer.cipher_alg)
            `CHK("on", (i > 0 && i < 6), steer.cipher_on)
            `CHK("dec", 1'(i % 2), steer.decrypt)
            `CHK("ksw", (i % 4 < 2), steer.key_from_sw)
            `CHK("khi", (i % 4 == 3), steer.key_region_hi)
        end
        wr(8'h00, 32'h0000_0000);
        wr(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_0002);
        settle();
        `CHK("kdma", 1'b1, steer.key_from_dma)
        `CHK("hxor", 1'b1, steer.hmac_xor)
        pulse(9'h008);
        rc(8'h04, 32'h0, 1'b0);
        rc(8'h08, 32'h0, 1'b0);
        rc(8'h00, 32'h4100_0000, 1'b0);
        $display("test cipher done");
    endtask
    task automatic t_digest;
        for (int h = 0; h < 7; h++) begin
            wr(8'h08, 32'(h) << 2);
            settle();
            `CHK("halg", 3'(h), steer.hash_alg)
            `CHK("hon", (h > 0 && h < 6), steer.hash_on)
        end
        wr(8'h08, 32'h0000_0034);
        settle();
        `CHK("last", 1'b1, steer.hash_last)
        pulse(9'h040);
        rc(8'h08, 32'h0000_0014, 1'b0);
        rc(8'h00, 32'hC500_0000, 1'b0);
        wr(8'h08, 32'h0000_0015);
        k = 0;
        repeat (3) begin
            @(negedge mclk) k += init_start;
        end
        `CHK("init_start", 1, k)
        rc(8'h08, 32'h0000_0014, 1'b0);
        pulse(9'h001);
        rc(8'h08, 32'h0000_0015, 1'b0);
        $display("test digest done");
    endtask
    task automatic t_paths;
        wr(8'h00, 32'h0000_0634);
        @(posedge mclk) {in_valid, in_full, out_valid} <= 3'h7;
        settle();
        `CHK("rd_dma", 1'b1, steer.rd_from_dma)
        `CHK("wr_rdf", 1'b1, steer.wr_from_rdfifo)
        `CHK("h_out", 1'b1, steer.hash_from_out)
        `CHK("in_q", 32'h4433_2211, in_q_data)
        `CHK("out_q", 32'h5566_7788, out_q_data)
        `CHK("in_qv", 1'b1, in_q_valid)
        `CHK("out_qv", 1'b1, out_q_valid)
        wr(8'h00, 32'h0000_0910);
        @(posedge mclk) out_full <= 1'b1;
        settle();
        `CHK("rd_rng", 1'b1, steer.rd_from_rng)
        `CHK("wr_ciph", 1'b1, steer.wr_from_cipher)
        `CHK("h_in", 1'b0, steer.hash_from_out)
        `CHK("in_q", 32'h1122_3344, in_q_data)
        `CHK("out_q", 32'h8877_6655, out_q_data)
        $display("test paths done");
    endtask
    // ==========================================================
    // Verdict, watchdog and main sequence.
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // The tests need a few hundred cycles; the limit leaves wide margin.
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_flags();
        t_maa();
        t_err_rst();
        t_cipher();
        t_digest();
        t_paths();
        report_and_stop();
    end
endmodule
